// >>> src/fsq_regs.svh
// Opcodes, status field layout, reset values and timing counts
//
// Contract
// (RULE1) Bytes travel MSB first; sample on rising, drive on falling edges.
// (RULE2) Write-enable opcode sets the write enable latch.
// (RULE3) Host issues volatile write enable right before a status write.
// (RULE4) Volatile enable keeps the latch; next status write is volatile.
// (RULE5) Write-disable opcode clears the write enable latch.
// (RULE6) Latch clears at power-up and when writes or other operations end.
// (RULE7) Read-status opcodes shift out status one, two or three, MSB first.
// (RULE8) Status reads accepted anytime; repeat while chip select stays low.
// (RULE9) Busy-interrupt opcode drives busy onto output; no clocks needed.
// (RULE10) In busy-interrupt mode output falls when busy clears and stays low. Code follows busy, so the output rises again if ext_busy_i returns.
// (RULE11) Chip select high ends busy-interrupt mode and releases the output.
// (RULE12) First status write: byte one to status one, byte two to two.
// (RULE13) Second and third status writes take one byte for status two, three.
// (RULE14) Only protect, block, complement, lock, quad, drive bits writable.
// (RULE15) Security lock bits are one-time programmable; set bits stay set.
// (RULE16) Status write needs a prior write enable or volatile write enable.
// (RULE17) Status write never changes suspend flags, latch or busy.
// (RULE18) Chip select must rise after exactly 8 or 16 data bits.
// (RULE19) Valid status write starts timed busy cycle; end clears busy, latch.
// (RULE20) No status write executes in hardware protected mode.
// (RULE21) Normal read: 24-bit address, then bytes with auto-increment.
// (RULE22) Normal read while busy is ignored and leaves the cycle alone.
// (RULE23) Normal read exists only in single-line serial mode.
// (RULE24) Fast read inserts eight dummy clocks after the address.
// (RULE25) Output released while chip select high or nothing returns data.
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH

`define FSQ_OP_WRITE_ENABLE 8'h06
`define FSQ_OP_VOL_WRITE_ENABLE 8'h50
`define FSQ_OP_WRITE_DISABLE 8'h04
`define FSQ_OP_READ_SR1 8'h05
`define FSQ_OP_READ_SR2 8'h35
`define FSQ_OP_READ_SR3 8'h15
`define FSQ_OP_BUSY_INT 8'h25
`define FSQ_OP_WRITE_SR1 8'h01
`define FSQ_OP_WRITE_SR2 8'h31
`define FSQ_OP_WRITE_SR3 8'h11
`define FSQ_OP_READ 8'h03
`define FSQ_OP_FAST_READ 8'h0B

`define FSQ_SR1_WMASK 8'hFC
`define FSQ_SR2_WMASK 8'h7B
`define FSQ_SR3_WMASK 8'h60
`define FSQ_SR2_LOCK_MASK 8'h38
`define FSQ_SR1_PROT_BIT 7
`define FSQ_SR2_PROT_BIT 0
`define FSQ_SR2_PSUS_BIT 2
`define FSQ_SR2_ESUS_BIT 7
`define FSQ_SR1_RESET 8'h00
`define FSQ_SR2_RESET 8'h00
`define FSQ_SR3_RESET 8'h00

`define FSQ_ADDR_BITS 24
`define FSQ_DUMMY_BITS 8
`define FSQ_CORE_CLK_MHZ 10
`define FSQ_SW_CYCLE_US 5
`define FSQ_SW_CYCLES (`FSQ_SW_CYCLE_US * `FSQ_CORE_CLK_MHZ)

`endif

// >>> src/fsq_pkg.sv
// Types shared by the flash status/read sequencer
package fsq_pkg;
  typedef enum logic [3:0] {
    st_opcode, st_cmd, st_addr, st_dummy, st_read,
    st_stat, st_bint, st_status_write_cmd, st_ign
  } fsq_state_type;
endpackage

// >>> src/fsq_buf_if.sv
// Byte stream carrier between the sequencer and its read buffer
`timescale 1ns/1ps
interface fsq_buf_if;
  logic flush;
  logic in_valid;
  logic in_ready;
  logic [7:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  modport store (input flush, in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
  modport user (output flush, in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

// >>> src/fsq_buf.sv
// Two-entry read data buffer with valid/ready on both sides
`timescale 1ns/1ps
module fsq_buf (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Stream
  fsq_buf_if.store bp
);
  localparam int DEPTH = 2;
  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];
  logic wptr_q, wptr_d, rptr_q, rptr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign bp.in_ready = (cnt_q != 2'(DEPTH));
  assign bp.out_valid = (cnt_q != 2'h0);
  assign bp.out_data = mem_q[rptr_q];
  assign push = bp.in_valid && bp.in_ready;
  assign pop = bp.out_valid && bp.out_ready;

  always_comb begin
    mem_d = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    if (bp.flush) begin
      wptr_d = 1'b0;
      rptr_d = 1'b0;
      cnt_d = 2'h0;
    end else begin
      if (push) begin
        mem_d[wptr_q] = bp.in_data;
        wptr_d = ~wptr_q;
      end
      if (pop) begin
        rptr_d = ~rptr_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q <= '{default: 8'h00};
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

// >>> src/fsq_core.sv
// Serial flash command sequencer: status, busy interrupt and reads
`timescale 1ns/1ps
`include "fsq_regs.svh"
module fsq_core #(
  parameter int unsigned TW_CYCLES = `FSQ_SW_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Serial pins
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic wp_b_i,
  output logic so_o,
  output logic so_oe_o,
  // Array read stream
  output logic mem_rd_o,
  output logic [23:0] mem_addr_o,
  input wire logic mem_valid_i,
  input wire logic [7:0] mem_data_i,
  output logic mem_ready_o,
  // Array operations outside this block
  input wire logic ext_busy_i,
  input wire logic ext_op_done_i,
  input wire logic erase_suspend_flag_i,
  input wire logic program_suspend_flag_i,
  // Status view
  output logic [23:0] status_o
);
  // Pin synchroniser: cs, sclk, si, wp; stage three only for edges
  logic [3:0] sync1_q, sync2_q;
  logic [1:0] sync3_q;
  logic cs_s, sclk_s, si_s, wp_s, sclk_rise, sclk_fall, cs_rise;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sync3_q <= 2'h3;
    end else begin
      sync1_q <= {wp_b_i, si_i, sclk_i, cs_b_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[1:0];
    end
  end
  assign cs_s = sync2_q[0];
  assign sclk_s = sync2_q[1];
  assign si_s = sync2_q[2];
  assign wp_s = sync2_q[3];
  assign cs_rise = cs_s && !sync3_q[0];
  assign sclk_rise = !cs_s && sclk_s && !sync3_q[1];
  assign sclk_fall = !cs_s && !sclk_s && sync3_q[1];

  fsq_buf_if bif ();
  fsq_buf u_buf (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .bp(bif)
  );

  fsq_pkg::fsq_state_type state_q, state_d;
  logic [7:0] shift_q, shift_d, op_q, op_d, tx_q, tx_d;
  logic [4:0] bitcnt_q, bitcnt_d;
  logic [2:0] txcnt_q, txcnt_d;
  logic [23:0] addr_q, addr_d, pend_q, pend_d;
  logic [7:0] sr1_q, sr1_d, sr2_q, sr2_d, sr3_q, sr3_d;
  logic [15:0] twcnt_q, twcnt_d;
  logic so_q, so_d, oe_q, oe_d, wel_q, wel_d, vwe_q, vwe_d;
  logic busy_q, busy_d, pop, flush;
  logic write_in_progress, hw_prot, status_write_cmd_ok;
  logic [7:0] opfull, view1, view2, view3, vsel, byte_out;
  logic [7:0] b1, b2, b3;

  assign write_in_progress = busy_q || ext_busy_i;
  assign view1 = {sr1_q[7:2], wel_q, write_in_progress};
  always_comb begin
    view2 = sr2_q;
    view2[`FSQ_SR2_PSUS_BIT] = program_suspend_flag_i;
    view2[`FSQ_SR2_ESUS_BIT] = erase_suspend_flag_i;
  end
  assign view3 = sr3_q;
  assign status_o = {view3, view2, view1};
  assign opfull = {shift_q[6:0], si_s}; // RULE1
  assign vsel = (op_q == `FSQ_OP_READ_SR2) ? view2 :
                (op_q == `FSQ_OP_READ_SR3) ? view3 : view1; // RULE7
  // Power-supply lock, or pin lock with the pin held low
  assign hw_prot = (sr2_q[`FSQ_SR2_PROT_BIT] && !sr1_q[`FSQ_SR1_PROT_BIT]) ||
                   (sr1_q[`FSQ_SR1_PROT_BIT] && !sr2_q[`FSQ_SR2_PROT_BIT]
                    && !wp_s); // RULE20
  // Exact 8 or 16 bit boundary and an enable beforehand
  assign status_write_cmd_ok = cs_rise && state_q == fsq_pkg::st_status_write_cmd &&
                   (bitcnt_q == 5'd8 ||
                    (op_q == `FSQ_OP_WRITE_SR1 && bitcnt_q == 5'd16)) &&
                   (wel_q || vwe_q) && !hw_prot && !write_in_progress; // RULE16 RULE18

  // Data bytes mapped to targets; an unwritten target keeps its value
  always_comb begin
    b1 = sr1_q;
    b2 = sr2_q;
    b3 = sr3_q;
    if (op_q == `FSQ_OP_WRITE_SR1 && bitcnt_q == 5'd16) begin
      b1 = addr_q[15:8];
      b2 = addr_q[7:0];
    end else if (op_q == `FSQ_OP_WRITE_SR1) begin
      b1 = addr_q[7:0]; // RULE12
    end else if (op_q == `FSQ_OP_WRITE_SR2) begin
      b2 = addr_q[7:0]; // RULE13
    end else begin
      b3 = addr_q[7:0];
    end
  end

  assign mem_rd_o = !cs_s && (state_q == fsq_pkg::st_dummy ||
                              state_q == fsq_pkg::st_read);
  assign mem_addr_o = addr_q;
  assign mem_ready_o = bif.in_ready && mem_rd_o;
  assign bif.in_valid = mem_valid_i && mem_rd_o;
  assign bif.in_data = mem_data_i;
  assign bif.out_ready = pop;
  assign bif.flush = flush;
  assign so_o = so_q;
  assign so_oe_o = oe_q;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bitcnt_d = bitcnt_q;
    op_d = op_q;
    addr_d = addr_q;
    tx_d = tx_q;
    txcnt_d = txcnt_q;
    so_d = so_q;
    wel_d = wel_q;
    vwe_d = vwe_q;
    sr1_d = sr1_q;
    sr2_d = sr2_q;
    sr3_d = sr3_q;
    pend_d = pend_q;
    busy_d = busy_q;
    twcnt_d = twcnt_q;
    pop = 1'b0;
    flush = 1'b0;
    byte_out = 8'hFF;
    if (ext_op_done_i) wel_d = 1'b0; // RULE6
    if (busy_q) begin
      if (twcnt_q == 16'h0000) begin
        busy_d = 1'b0;
        wel_d = 1'b0;
        {sr3_d, sr2_d, sr1_d} = pend_q; // RULE19
      end else begin
        twcnt_d = twcnt_q - 16'h0001;
      end
    end
    if (mem_rd_o && bif.in_valid && bif.in_ready) begin
      addr_d = addr_q + 24'h000001; // RULE21
    end
    if (cs_s) begin
      state_d = fsq_pkg::st_opcode; // RULE11 RULE25
      bitcnt_d = 5'd0;
      txcnt_d = 3'd0;
      so_d = 1'b0;
      if (cs_rise && state_q != fsq_pkg::st_opcode) begin
        vwe_d = 1'b0;
        if (state_q == fsq_pkg::st_cmd && !write_in_progress) begin
          if (op_q == `FSQ_OP_WRITE_ENABLE) wel_d = 1'b1; // RULE2
          if (op_q == `FSQ_OP_WRITE_DISABLE) wel_d = 1'b0; // RULE5
          if (op_q == `FSQ_OP_VOL_WRITE_ENABLE) vwe_d = 1'b1; // RULE4
        end
        if (status_write_cmd_ok) begin
          // Writable bits only; lock bits can only go up
          pend_d[7:0] = (sr1_q & ~`FSQ_SR1_WMASK) |
                        (b1 & `FSQ_SR1_WMASK); // RULE14 RULE17
          pend_d[15:8] = (sr2_q & ~`FSQ_SR2_WMASK) |
                         (b2 & `FSQ_SR2_WMASK) |
                         (sr2_q & `FSQ_SR2_LOCK_MASK); // RULE15
          pend_d[23:16] = (sr3_q & ~`FSQ_SR3_WMASK) |
                          (b3 & `FSQ_SR3_WMASK);
          if (vwe_q) begin
            {sr3_d, sr2_d, sr1_d} = pend_d; // RULE4
          end else begin
            busy_d = 1'b1; // RULE19
            twcnt_d = 16'(TW_CYCLES - 1);
          end
        end
      end
    end else if (sclk_rise) begin
      unique case (state_q)
        fsq_pkg::st_opcode: begin
          shift_d = opfull;
          bitcnt_d = bitcnt_q + 5'd1;
          if (bitcnt_q == 5'd7) begin
            op_d = opfull;
            bitcnt_d = 5'd0;
            // Only single-line opcodes are decoded here
            unique case (opfull)
              `FSQ_OP_WRITE_ENABLE, `FSQ_OP_WRITE_DISABLE,
              `FSQ_OP_VOL_WRITE_ENABLE:
                state_d = fsq_pkg::st_cmd;
              `FSQ_OP_READ_SR1, `FSQ_OP_READ_SR2, `FSQ_OP_READ_SR3:
                state_d = fsq_pkg::st_stat; // RULE8
              `FSQ_OP_BUSY_INT:
                state_d = fsq_pkg::st_bint; // RULE9
              `FSQ_OP_WRITE_SR1, `FSQ_OP_WRITE_SR2, `FSQ_OP_WRITE_SR3:
                state_d = write_in_progress ? fsq_pkg::st_ign : fsq_pkg::st_status_write_cmd;
              `FSQ_OP_READ, `FSQ_OP_FAST_READ: begin
                state_d = write_in_progress ? fsq_pkg::st_ign
                              : fsq_pkg::st_addr; // RULE22 RULE23
                flush = 1'b1;
              end
              default: state_d = fsq_pkg::st_ign;
            endcase
          end
        end
        fsq_pkg::st_addr: begin
          addr_d = {addr_q[22:0], si_s}; // RULE1
          bitcnt_d = bitcnt_q + 5'd1;
          if (bitcnt_q == 5'(`FSQ_ADDR_BITS - 1)) begin
            bitcnt_d = 5'd0;
            state_d = (op_q == `FSQ_OP_FAST_READ) ? fsq_pkg::st_dummy
                                                 : fsq_pkg::st_read; // RULE21
          end
        end
        fsq_pkg::st_dummy: begin
          bitcnt_d = bitcnt_q + 5'd1;
          if (bitcnt_q == 5'(`FSQ_DUMMY_BITS - 1)) begin
            state_d = fsq_pkg::st_read; // RULE24
          end
        end
        fsq_pkg::st_status_write_cmd: begin
          addr_d = {addr_q[22:0], si_s};
          if (bitcnt_q != 5'd31) bitcnt_d = bitcnt_q + 5'd1;
        end
        fsq_pkg::st_cmd, fsq_pkg::st_read, fsq_pkg::st_stat,
        fsq_pkg::st_bint, fsq_pkg::st_ign: begin
        end
        default: state_d = fsq_pkg::st_ign;
      endcase
    end else if (sclk_fall && (state_q == fsq_pkg::st_stat ||
                               state_q == fsq_pkg::st_read)) begin
      txcnt_d = txcnt_q + 3'd1;
      if (txcnt_q == 3'd0) begin
        if (state_q == fsq_pkg::st_stat) begin
          byte_out = vsel; // RULE8
        end else if (bif.out_valid) begin
          byte_out = bif.out_data;
          pop = 1'b1;
        end
        so_d = byte_out[7]; // RULE1 RULE7
        tx_d = {byte_out[6:0], 1'b0};
      end else begin
        so_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
    // Tracks busy on the core clock, so no serial clock is needed
    if (!cs_s && state_q == fsq_pkg::st_bint) so_d = write_in_progress; // RULE9 RULE10
    oe_d = !cs_s && (state_d == fsq_pkg::st_stat ||
                     state_d == fsq_pkg::st_read ||
                     state_d == fsq_pkg::st_bint); // RULE25
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_q <= fsq_pkg::st_opcode;
      shift_q <= 8'h00;
      bitcnt_q <= 5'd0;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      tx_q <= 8'h00;
      txcnt_q <= 3'd0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      wel_q <= 1'b0; // RULE6
      vwe_q <= 1'b0;
      sr1_q <= `FSQ_SR1_RESET;
      sr2_q <= `FSQ_SR2_RESET;
      sr3_q <= `FSQ_SR3_RESET;
      pend_q <= 24'h000000;
      busy_q <= 1'b0;
      twcnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitcnt_q <= bitcnt_d;
      op_q <= op_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      txcnt_q <= txcnt_d;
      so_q <= so_d;
      oe_q <= oe_d;
      wel_q <= wel_d;
      vwe_q <= vwe_d;
      sr1_q <= sr1_d;
      sr2_q <= sr2_d;
      sr3_q <= sr3_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      twcnt_q <= twcnt_d;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_cmd_end(logic [7:0] op);
    cs_rise && state_q == fsq_pkg::st_cmd && op_q == op && !write_in_progress;
  endsequence

  property p_wel_set;
    s_cmd_end(`FSQ_OP_WRITE_ENABLE) |=> wel_q;
  endproperty
  a_wel_set: assert property (p_wel_set) // RULE2
    else $error("write enable did not set latch");

  property p_vwe_keeps_wel;
    s_cmd_end(`FSQ_OP_VOL_WRITE_ENABLE) ##0 !ext_op_done_i
      |=> wel_q == $past(wel_q) && vwe_q;
  endproperty
  a_vwe_keeps_wel: assert property (p_vwe_keeps_wel) // RULE4
    else $error("volatile enable changed latch");

  property p_wel_clr;
    s_cmd_end(`FSQ_OP_WRITE_DISABLE) |=> !wel_q;
  endproperty
  a_wel_clr: assert property (p_wel_clr) // RULE5
    else $error("write disable did not clear latch");

  property p_release;
    cs_s |=> !so_oe_o;
  endproperty
  a_release: assert property (p_release) // RULE11
    else $error("output driven with chip select high");

  property p_bint_track;
    state_q == fsq_pkg::st_bint && !cs_s |=> so_o == $past(write_in_progress) && so_oe_o;
  endproperty
  a_bint_track: assert property (p_bint_track) // RULE9
    else $error("busy interrupt output not tracking busy");

  property p_cycle_end;
    $fell(busy_q) |-> !wel_q;
  endproperty
  a_cycle_end: assert property (p_cycle_end) // RULE19
    else $error("latch set after status write cycle");

  property p_lock_otp;
    ($past(sr2_q) & ~sr2_q & `FSQ_SR2_LOCK_MASK) == 8'h00;
  endproperty
  a_lock_otp: assert property (p_lock_otp) // RULE15
    else $error("security lock bit cleared");

  property p_prot_blocks;
    cs_rise && state_q == fsq_pkg::st_status_write_cmd && hw_prot
      |=> !busy_q && {sr3_q, sr2_q, sr1_q} == $past({sr3_q, sr2_q, sr1_q});
  endproperty
  a_prot_blocks: assert property (p_prot_blocks) // RULE20
    else $error("status write executed while protected");

  property p_read_busy_ignored;
    sclk_rise && state_q == fsq_pkg::st_opcode && bitcnt_q == 5'd7 &&
      opfull == `FSQ_OP_READ && write_in_progress |=> state_q == fsq_pkg::st_ign;
  endproperty
  a_read_busy_ignored: assert property (p_read_busy_ignored) // RULE22
    else $error("read accepted while busy");

  property p_addr_inc;
    mem_rd_o && mem_valid_i && mem_ready_o
      |=> mem_addr_o == $past(mem_addr_o) + 24'h000001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) // RULE21
    else $error("read address did not advance");
endmodule

// >>> bench/fsq_host.sv
// Host side model of the serial link: mode 0 frames, MSB first
`timescale 1ns/1ps
module fsq_host (
  // Serial pins
  output logic cs_b_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  // Clock stands low outside frames; first rise well after select falls
  task automatic open_frame();
    cs_b_o = 1'b0;
    #400;
  endtask

  // Select rises only after the last falling clock edge of the frame
  task automatic close_frame();
    #200;
    cs_b_o = 1'b1;
    si_o = ~si_o;
    #800;
  endtask

  // One byte each way; device shifts on falls, so sampling on rises is safe
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o = tx[i];
      #400;
      sclk_o = 1'b1;
      rx[i] = so_oe_i ? so_i : 1'bx;
      #400;
      sclk_o = 1'b0;
    end
  endtask
endmodule

// >>> bench/fsq_core_tb.sv
// Self-checking bench for the flash status and read sequencer
`timescale 1ns/1ps
`include "fsq_regs.svh"
module fsq_core_tb;
  // Long enough that a busy interrupt opcode fits inside one write cycle
  localparam int TW = 400;
  localparam int LIMIT = 40000;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cs_b, sclk, si, so, so_oe, mem_rd, mem_valid, mem_ready;
  logic wp_b = 1'b1;
  logic stall_q = 1'b0;
  logic ext_busy = 1'b0;
  logic op_done = 1'b0;
  logic esus = 1'b1;
  logic psus = 1'b0;
  logic write_enable_latch = 1'b0;
  logic [23:0] mem_addr, status, a;
  logic [7:0] e1 = 8'h00;
  logic [7:0] e2 = 8'h00;
  logic [7:0] e3 = 8'h00;
  logic [7:0] rx, d1, d2;
  logic [7:0] ops [3] = '{`FSQ_OP_READ_SR1, `FSQ_OP_READ_SR2,
                          `FSQ_OP_READ_SR3};
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int oe_hits = 0;
  int takes = 0;
  int n, c0;
  integer seed = 32'h6e18;

  fsq_host h (.cs_b_o(cs_b), .sclk_o(sclk), .si_o(si), .so_i(so),
              .so_oe_i(so_oe));

  fsq_core #(.TW_CYCLES(TW)) dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
    .sclk_i(sclk), .si_i(si), .wp_b_i(wp_b), .so_o(so), .so_oe_o(so_oe),
    .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_valid_i(mem_valid),
    .mem_data_i(mbyte(mem_addr)), .mem_ready_o(mem_ready),
    .ext_busy_i(ext_busy), .ext_op_done_i(op_done),
    .erase_suspend_flag_i(esus), .program_suspend_flag_i(psus),
    .status_o(status)
  );

  // Array answers at once or after one stalled cycle, never later
  assign mem_valid = mem_rd & ~stall_q;

  always #50 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    stall_q <= ~stall_q & ($random(seed) % 2 != 0);
    oe_hits <= oe_hits + ((so_oe === 1'b1) ? 1 : 0);
    takes <= takes + ((mem_valid && mem_ready) ? 1 : 0);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  function automatic logic [7:0] mbyte(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5A;
  endfunction

  function automatic logic [7:0] upd(input logic [7:0] o, d, m);
    return (d & m) | (o & ~m);
  endfunction

  // Lock bits only ever gain ones
  function automatic logic [7:0] upd2(input logic [7:0] o, d);
    return upd(o, d, `FSQ_SR2_WMASK) | (o & `FSQ_SR2_LOCK_MASK);
  endfunction

  function automatic logic [7:0] sr(input int k);
    if (k == 1) return {e1[7:2], write_enable_latch, ext_busy};
    if (k == 2) return e2 | {esus, 4'h0, psus, 2'h0};
    return e3;
  endfunction

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    h.open_frame();
    h.xfer(op, rx);
    h.close_frame();
  endtask

  task automatic rd_stat(input logic [7:0] op, input int k);
    h.open_frame();
    h.xfer(op, rx);
    repeat (2) begin
      h.xfer(8'h00, rx);
      chk(24'(rx), 24'(sr(k)));
    end
    h.close_frame();
  endtask

  task automatic wr_stat(input logic [7:0] op, x, y, input int nb);
    h.open_frame();
    h.xfer(op, rx);
    h.xfer(x, rx);
    if (nb > 1) h.xfer(y, rx);
    if (nb > 2) h.xfer(y, rx);
    h.close_frame();
  endtask

  task automatic all_stat();
    rd_stat(`FSQ_OP_READ_SR1, 1);
    rd_stat(`FSQ_OP_READ_SR2, 2);
    chk(status, {e3, sr(2), sr(1)});
  endtask

  initial begin
    repeat (8) @(posedge core_clk_i);
    #5 rst_b_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #5;
    foreach (ops[i]) rd_stat(ops[i], i + 1);
    cmd(`FSQ_OP_WRITE_ENABLE);
    write_enable_latch = 1'b1;
    rd_stat(`FSQ_OP_READ_SR1, 1);
    cmd(`FSQ_OP_WRITE_DISABLE);
    write_enable_latch = 1'b0;
    rd_stat(`FSQ_OP_READ_SR1, 1);
    cmd(`FSQ_OP_VOL_WRITE_ENABLE);
    rd_stat(`FSQ_OP_READ_SR1, 1);
    // Volatile writes through every status write form
    for (int i = 0; i < 8; i++) begin
      d1 = (i == 0) ? 8'hFF : 8'($random(seed));
      d2 = (i == 2) ? 8'hFE : (i == 6) ? 8'h00 : 8'($random(seed));
      d2[0] = 1'b0;
      psus = i[0];
      esus = ~i[0];
      cmd(`FSQ_OP_VOL_WRITE_ENABLE);
      case (i % 4)
        0: wr_stat(`FSQ_OP_WRITE_SR1, d1, d2, 1);
        1: wr_stat(`FSQ_OP_WRITE_SR1, d1, d2, 2);
        2: wr_stat(`FSQ_OP_WRITE_SR2, d2, d1, 1);
        default: wr_stat(`FSQ_OP_WRITE_SR3, d1, d2, 1);
      endcase
      if (i % 4 < 2) e1 = upd(e1, d1, `FSQ_SR1_WMASK);
      if (i % 4 == 1 || i % 4 == 2) e2 = upd2(e2, d2);
      if (i % 4 == 3) e3 = upd(e3, d1, `FSQ_SR3_WMASK);
      all_stat();
    end
    wr_stat(`FSQ_OP_WRITE_SR3, ~e3, 8'h00, 1);
    cmd(`FSQ_OP_VOL_WRITE_ENABLE);
    wr_stat(`FSQ_OP_WRITE_SR1, ~e1, ~e1, 3);
    chk(status, {e3, sr(2), sr(1)});
    // Timed write watched through the busy interrupt mode
    cmd(`FSQ_OP_WRITE_ENABLE);
    write_enable_latch = 1'b1;
    d1 = 8'($random(seed));
    wr_stat(`FSQ_OP_WRITE_SR1, d1, d1, 1);
    c0 = cyc - 8;
    e1 = upd(e1, d1, `FSQ_SR1_WMASK);
    chk(24'(status[1:0]), 24'h3);
    h.open_frame();
    h.xfer(`FSQ_OP_BUSY_INT, rx);
    #400;
    chk(24'({so_oe, so}), 24'h3);
    n = 0;
    while (status[0] !== 1'b0 && n < TW) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(24'(cyc - c0 > TW - 30 && cyc - c0 < TW + 5), 24'h1);
    repeat (4) @(posedge core_clk_i);
    #5 chk(24'({so_oe, so}), 24'h2);
    h.close_frame();
    chk(24'(so_oe), 24'h0);
    write_enable_latch = 1'b0;
    all_stat();
    // Array busy: status still answers, normal read stays silent
    @(posedge core_clk_i) #5 ext_busy = 1'b1;
    rd_stat(`FSQ_OP_READ_SR1, 1);
    n = oe_hits;
    h.open_frame();
    h.xfer(`FSQ_OP_READ, rx);
    repeat (4) h.xfer(8'h00, rx);
    h.close_frame();
    chk(24'(oe_hits - n), 24'h0);
    @(posedge core_clk_i) #5 ext_busy = 1'b0;
    cmd(`FSQ_OP_WRITE_ENABLE);
    write_enable_latch = 1'b1;
    rd_stat(`FSQ_OP_READ_SR1, 1);
    @(posedge core_clk_i) #5 op_done = 1'b1;
    @(posedge core_clk_i) #5 op_done = 1'b0;
    write_enable_latch = 1'b0;
    rd_stat(`FSQ_OP_READ_SR1, 1);
    // Reset in mid-run with the latch and status registers set
    cmd(`FSQ_OP_WRITE_ENABLE);
    @(posedge core_clk_i) #5 rst_b_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #5 rst_b_i = 1'b1;
    e1 = 8'h00;
    e2 = 8'h00;
    e3 = 8'h00;
    repeat (4) @(posedge core_clk_i);
    #5 all_stat();
    // Normal and fast reads, first one running over the top address
    for (int j = 0; j < 4; j++) begin
      a = (j == 0) ? 24'hFFFFFE : 24'($random(seed));
      n = takes;
      h.open_frame();
      h.xfer(j[0] ? `FSQ_OP_FAST_READ : `FSQ_OP_READ, rx);
      for (int b = 2; b >= 0; b--) h.xfer(a[8*b +: 8], rx);
      if (j[0]) h.xfer(8'h00, rx);
      for (int b = 0; b < 3; b++) begin
        h.xfer(8'h00, rx);
        chk(24'(rx), 24'(mbyte(a + 24'(b))));
      end
      h.close_frame();
      chk(24'(takes - n > 3), 24'h1);
      chk(mem_addr, a + 24'(takes - n));
    end
    // Protect bit with write protect pin low blocks any status write
    cmd(`FSQ_OP_VOL_WRITE_ENABLE);
    wr_stat(`FSQ_OP_WRITE_SR1, 8'h80, 8'h00, 1);
    e1 = upd(e1, 8'h80, `FSQ_SR1_WMASK);
    @(posedge core_clk_i) #5 wp_b = 1'b0;
    cmd(`FSQ_OP_VOL_WRITE_ENABLE);
    wr_stat(`FSQ_OP_WRITE_SR3, ~e3, 8'h00, 1);
    chk(status, {e3, sr(2), sr(1)});
    complete_run();
  end
endmodule
